// ---- core/pmf_defines.svh ----
`ifndef PMF_DEFINES_SVH
`define PMF_DEFINES_SVH

`define PMF_NCELL 32
`define PMF_NPT 5
`define PMF_NDED 4
`define PMF_CHAIN_LEN 8
`define PMF_PT_WORDS 6
`define PMF_PT_MEM 960
`define PMF_SLEEP_PIN 31
`define PMF_XOR_PT 4

`define PMF_OFS_CTRL 32'h0000_0000
`define PMF_OFS_STATUS 32'h0000_0004
`define PMF_OFS_STATE 32'h0000_0008
`define PMF_OFS_PINS 32'h0000_000c
`define PMF_OFS_CELL 32'h0000_0080
`define PMF_OFS_CELL_END 32'h0000_0100
`define PMF_OFS_PT 32'h0000_1000
`define PMF_OFS_PT_END 32'h0000_1f00

`define PMF_CTRL_SLEEP_OPT 0
`define PMF_CTRL_KEEPER 1
`define PMF_CTRL_RESET 32'h0000_0002

`define PMF_CELL_OR_LSB 0
`define PMF_CELL_XOR_LSB 5
`define PMF_CELL_FOLD_LSB 7
`define PMF_CELL_CASC 10
`define PMF_CELL_CLK_LSB 11
`define PMF_CELL_RST_EN 13
`define PMF_CELL_RST_LSB 14
`define PMF_CELL_OE_LSB 16
`define PMF_CELL_OESRC_LSB 18
`define PMF_CELL_COMB 20
`define PMF_CELL_RESET 32'h0000_0000

`define PMF_RESP_OKAY 2'h0
`define PMF_RESP_SLVERR 2'h2

`endif

// ---- core/pmf_pkg.sv ----
package pmf_pkg;
    typedef enum logic [1:0] {pmf_xor_low, pmf_xor_high, pmf_xor_pt, pmf_xor_state} pmf_xor_sel_t;
    typedef enum logic [1:0] {pmf_oe_off, pmf_oe_on, pmf_oe_pin, pmf_oe_spare} pmf_oe_mode_t;
    typedef enum logic [2:0] {
        pmf_reg_ctrl, pmf_reg_status, pmf_reg_state, pmf_reg_pins, pmf_reg_cell, pmf_reg_pt, pmf_reg_none
    } pmf_reg_t;
endpackage

// ---- core/pmf_fabric.sv ----
`include "pmf_defines.svh"

module pmf_fabric (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [3:0] ded_in,
    input wire logic [3:0] ded_float,
    input wire logic [31:0] io_in,
    input wire logic [31:0] io_float,
    output logic [31:0] io_out,
    output logic [31:0] io_oe,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic rst_meta, rst_n;
    logic [31:0] ctrl, next_ctrl;
    logic [31:0] cell_cfg [`PMF_NCELL];
    logic [31:0] pt_mem [`PMF_PT_MEM];
    logic aw_have, next_aw_have, w_have, next_w_have, wr_go;
    logic [31:0] aw_addr, next_aw_addr, w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    pmf_pkg::pmf_reg_t wr_kind;
    logic asleep, next_asleep, sleep_request_pin;
    logic [31:0] io_lvl, next_io_lvl;
    logic [3:0] ded_lvl, next_ded_lvl, ded_prev, next_ded_prev;
    logic [31:0] state, next_state, fold_q, next_fold, next_oe, chain;
    logic [67:0] gbus;
    logic [95:0] lit;
    logic [4:0] pt [`PMF_NCELL];
    logic [31:0] cfg;
    logic carry, xin, d;
    logic [9:0] b;

    function automatic pmf_pkg::pmf_reg_t decode(input logic [31:0] a);
        if (a >= `PMF_OFS_PT && a < `PMF_OFS_PT_END)
            return pmf_pkg::pmf_reg_pt;
        if (a >= `PMF_OFS_CELL && a < `PMF_OFS_CELL_END)
            return pmf_pkg::pmf_reg_cell;
        case ({a[31:2], 2'h0})
            `PMF_OFS_CTRL: return pmf_pkg::pmf_reg_ctrl;
            `PMF_OFS_STATUS: return pmf_pkg::pmf_reg_status;
            `PMF_OFS_STATE: return pmf_pkg::pmf_reg_state;
            `PMF_OFS_PINS: return pmf_pkg::pmf_reg_pins;
            default: return pmf_pkg::pmf_reg_none;
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    // empty masks give a true term; padding literals are always low
    function automatic logic pt_eval(input logic [95:0] l, input logic [95:0] mt, input logic [95:0] mc);
        return (&(~mt | l)) & (&(~mc | ~l));
    endfunction

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    assign io_out = state;
    assign wr_go = aw_have & w_have & ~s_axi_bvalid;
    assign wr_kind = decode(aw_addr);

    always_comb begin
        next_aw_have = aw_have;
        next_aw_addr = aw_addr;
        next_w_have = w_have;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        next_ctrl = ctrl;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_have = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_have = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
            next_bvalid = 1'b0;
        if (wr_go) begin
            next_aw_have = 1'b0;
            next_w_have = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = (wr_kind == pmf_pkg::pmf_reg_none) ? `PMF_RESP_SLVERR : `PMF_RESP_OKAY;
            if (wr_kind == pmf_pkg::pmf_reg_ctrl)
                next_ctrl = merge(ctrl, w_data, w_strb);
        end
        if (s_axi_rvalid && s_axi_rready)
            next_rvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = `PMF_RESP_OKAY;
            case (decode(s_axi_araddr))
                pmf_pkg::pmf_reg_ctrl: next_rdata = ctrl;
                pmf_pkg::pmf_reg_status: next_rdata = {31'h0, asleep};
                pmf_pkg::pmf_reg_state: next_rdata = state;
                pmf_pkg::pmf_reg_pins: next_rdata = io_lvl;
                pmf_pkg::pmf_reg_cell: next_rdata = cell_cfg[s_axi_araddr[6:2]];
                pmf_pkg::pmf_reg_pt: next_rdata = pt_mem[s_axi_araddr[11:2]];
                default: begin
                    next_rdata = 32'h0;
                    next_rresp = `PMF_RESP_SLVERR;
                end
            endcase
        end
        next_awready = ~next_aw_have;
        next_wready = ~next_w_have;
        next_arready = ~next_rvalid;
    end

    // pin sampling, keepers and sleep
    always_comb begin
        sleep_request_pin = io_float[`PMF_SLEEP_PIN] ? (ctrl[`PMF_CTRL_KEEPER] & io_lvl[`PMF_SLEEP_PIN])
                                                     : io_in[`PMF_SLEEP_PIN];
        next_asleep = ctrl[`PMF_CTRL_SLEEP_OPT] & sleep_request_pin;
        next_io_lvl = (io_in & ~io_float) | (io_lvl & io_float & {32{ctrl[`PMF_CTRL_KEEPER]}});
        next_ded_lvl = (ded_in & ~ded_float) | (ded_lvl & ded_float & {4{ctrl[`PMF_CTRL_KEEPER]}});
        next_ded_prev = ded_lvl;
        if (asleep) begin
            next_io_lvl = io_lvl;
            next_ded_lvl = ded_lvl;
            next_ded_prev = ded_prev;
        end
    end

    // foldback is registered so regional feedback cannot form a combinational loop
    always_comb begin
        gbus = {state, io_lvl, ded_lvl};
        if (ctrl[`PMF_CTRL_SLEEP_OPT])
            gbus[`PMF_NDED + `PMF_SLEEP_PIN] = 1'b0;
        next_state = state;
        next_fold = fold_q;
        next_oe = io_oe;
        chain = 32'h0;
        carry = 1'b0;
        lit = 96'h0;
        cfg = 32'h0;
        xin = 1'b0;
        d = 1'b0;
        b = 10'h0;
        for (int c = 0; c < `PMF_NCELL; c++) begin
            cfg = cell_cfg[c];
            lit = {12'h0, (c >= 16) ? fold_q[31:16] : fold_q[15:0], gbus};
            for (int p = 0; p < `PMF_NPT; p++) begin
                b = 10'((c * `PMF_NPT + p) * `PMF_PT_WORDS);
                pt[c][p] = pt_eval(lit, {pt_mem[b + 10'h2], pt_mem[b + 10'h1], pt_mem[b]},
                                   {pt_mem[b + 10'h5], pt_mem[b + 10'h4], pt_mem[b + 10'h3]});
            end
            if (c % `PMF_CHAIN_LEN == 0)
                carry = 1'b0;
            carry = (|(pt[c] & cfg[`PMF_CELL_OR_LSB +: 5])) | (cfg[`PMF_CELL_CASC] & carry);
            chain[c] = carry;
            case (pmf_pkg::pmf_xor_sel_t'(cfg[`PMF_CELL_XOR_LSB +: 2]))
                pmf_pkg::pmf_xor_low: xin = 1'b0;
                pmf_pkg::pmf_xor_high: xin = 1'b1;
                pmf_pkg::pmf_xor_pt: xin = pt[c][`PMF_XOR_PT];
                pmf_pkg::pmf_xor_state: xin = state[c];
                default: xin = 1'b0;
            endcase
            d = carry ^ xin;
            if (cfg[`PMF_CELL_RST_EN] && !ded_lvl[cfg[`PMF_CELL_RST_LSB +: 2]])
                next_state[c] = 1'b0;
            else if (cfg[`PMF_CELL_COMB] ||
                     (ded_lvl[cfg[`PMF_CELL_CLK_LSB +: 2]] && !ded_prev[cfg[`PMF_CELL_CLK_LSB +: 2]]))
                next_state[c] = d;
            next_fold[c] = (cfg[`PMF_CELL_FOLD_LSB +: 3] < 3'h5) ? ~pt[c][cfg[`PMF_CELL_FOLD_LSB +: 3]] : 1'b0;
            case (pmf_pkg::pmf_oe_mode_t'(cfg[`PMF_CELL_OE_LSB +: 2]))
                pmf_pkg::pmf_oe_on: next_oe[c] = 1'b1;
                pmf_pkg::pmf_oe_pin: next_oe[c] = ~ded_lvl[cfg[`PMF_CELL_OESRC_LSB +: 2]];
                default: next_oe[c] = 1'b0;
            endcase
        end
        if (ctrl[`PMF_CTRL_SLEEP_OPT])
            next_oe[`PMF_SLEEP_PIN] = 1'b0;
        if (asleep) begin
            next_state = state;
            next_fold = fold_q;
            next_oe = io_oe;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            aw_have <= 1'b0;
            aw_addr <= 32'h0;
            w_have <= 1'b0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
            ctrl <= `PMF_CTRL_RESET;
            asleep <= 1'b0;
            io_lvl <= 32'h0;
            // idle high, so release of reset shows no false clock edge
            ded_lvl <= 4'hf;
            ded_prev <= 4'hf;
            state <= 32'h0;
            fold_q <= 32'h0;
            io_oe <= 32'h0;
            for (int i = 0; i < `PMF_NCELL; i++)
                cell_cfg[i] <= `PMF_CELL_RESET;
            for (int i = 0; i < `PMF_PT_MEM; i++)
                pt_mem[i] <= 32'h0;
        end else begin
            aw_have <= next_aw_have;
            aw_addr <= next_aw_addr;
            w_have <= next_w_have;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            ctrl <= next_ctrl;
            asleep <= next_asleep;
            io_lvl <= next_io_lvl;
            ded_lvl <= next_ded_lvl;
            ded_prev <= next_ded_prev;
            state <= next_state;
            fold_q <= next_fold;
            io_oe <= next_oe;
            if (wr_go && wr_kind == pmf_pkg::pmf_reg_cell)
                cell_cfg[aw_addr[6:2]] <= merge(cell_cfg[aw_addr[6:2]], w_data, w_strb);
            if (wr_go && wr_kind == pmf_pkg::pmf_reg_pt)
                pt_mem[aw_addr[11:2]] <= merge(pt_mem[aw_addr[11:2]], w_data, w_strb);
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    AST_SLEEP_ENTER: assert property (ctrl[0] && !io_float[31] && io_in[31] |=> asleep)
        else $error("sleep not entered");
    AST_SLEEP_HOLD: assert property (asleep |=> $stable(state) && $stable(io_oe) && $stable(fold_q))
        else $error("state moved while asleep");
    AST_SLEEP_PINS: assert property (asleep |=> $stable(io_lvl) && $stable(ded_lvl))
        else $error("pins sampled while asleep");
    AST_SLEEP_PIN_NOIO: assert property (ctrl[0] ##1 ctrl[0] |-> !io_oe[31] && !gbus[35])
        else $error("sleep pin used as logic io");
    AST_KEEPER_HOLD: assert property (!asleep && ctrl[1] && io_float[1] |=> io_lvl[1] == $past(io_lvl[1]))
        else $error("keeper lost level");
    AST_KEEPER_OFF: assert property (!asleep && !ctrl[1] && io_float[1] |=> !io_lvl[1])
        else $error("disabled keeper held level");
    AST_CELL_CLEAR: assert property (!asleep && cell_cfg[0][13] && !ded_lvl[cell_cfg[0][15:14]] |=> !io_out[0])
        else $error("selected clear ignored");
    AST_COMB_LOAD: assert property (!asleep && cell_cfg[0][20] && !cell_cfg[0][13] && cell_cfg[0][6:5] == 2'h1
                                    |=> io_out[0] == !$past(chain[0]))
        else $error("inverted sum not loaded");
    AST_FOLD: assert property (!asleep && cell_cfg[0][9:7] == 3'h0 |=> fold_q[0] == !$past(pt[0][0]))
        else $error("foldback not inverse of term");
    AST_CHAIN: assert property (cell_cfg[4][10] && chain[3] |-> chain[4])
        else $error("chain sum dropped");
endmodule

// ---- testbench/pmf_board.sv ----
module pmf_board (
    input wire logic clock,
    input wire logic [3:0] want_ded,
    input wire logic [3:0] want_ded_fl,
    input wire logic [31:0] want_io,
    input wire logic [31:0] want_io_fl,
    input wire logic [31:0] io_out,
    input wire logic [31:0] io_oe,
    output logic [3:0] ded_in,
    output logic [3:0] ded_float,
    output logic [31:0] io_in,
    output logic [31:0] io_float
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] io_last;
    logic [31:0] io_lvl;
    logic [31:0] io_drv;
    logic [3:0] ded_last;
    // a floated line shows the inverse of its last level, so only a real keeper holds it
    assign io_drv = ~want_io_fl | io_oe;
    assign io_lvl = (io_oe & io_out) | (~io_oe & want_io);
    initial begin
        {io_in, io_float, io_last, ded_float} = '0;
        ded_in = 4'hf;
        ded_last = 4'hf;
    end
    always @(posedge clock) begin
        // clear and gate lines idle high, pulled low only to assert
        ded_in <= (want_ded & ~want_ded_fl) | (~ded_last & want_ded_fl);
        ded_last <= (want_ded & ~want_ded_fl) | (ded_last & want_ded_fl);
        ded_float <= want_ded_fl;
        io_in <= (io_drv & io_lvl) | (~io_drv & ~io_last);
        io_last <= (io_drv & io_lvl) | (~io_drv & io_last);
        io_float <= ~io_drv;
    end
endmodule

// ---- testbench/pmf_fabric_test.sv ----
`include "pmf_defines.svh"
module pmf_fabric_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock;
    logic resetn;
    logic [3:0] want_ded, want_ded_fl, ded_in, ded_float, s_axi_wstrb;
    logic [31:0] want_io, want_io_fl, io_in, io_float, io_out, io_oe, snap;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int miscompares;
    int num_checks;
    // cell 0 config, dedicated pins, pin 1 level, expected out, expected enable
    logic [39:0] rows [9] = '{40'h00110001fe, 40'h00110001f2, 40'h00110021fa, 40'h00110021f6,
        40'h00110041fa, 40'h00120001ee, 40'h00120001fc, 40'h00116001da, 40'h00116001fe};

    pmf_fabric u_pmf_fabric (.clock, .resetn, .ded_in, .ded_float, .io_in, .io_float, .io_out, .io_oe,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    pmf_board u_pmf_board (.clock, .want_ded, .want_ded_fl, .want_io, .want_io_fl, .io_out, .io_oe,
        .ded_in, .ded_float, .io_in, .io_float);

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic print_verdict;
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic hang;
        miscompares++;
        print_verdict;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 100) hang;
        chk(32'(er), 32'(s_axi_bresp));
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clock);
            if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        s_axi_rready <= 1'b0;
        if (n == 100) hang;
        chk(ed, s_axi_rdata);
        chk(32'(er), 32'(s_axi_rresp));
    endtask

    initial begin
        int i;
        resetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, want_io, want_io_fl, want_ded_fl} = '0;
        s_axi_wstrb = 4'hf;
        want_ded = 4'hf;
        tick(6);
        resetn <= 1'b1;
        for (i = 0; i < 100 && s_axi_awready !== 1'b1; i++) tick(1);
        if (i == 100) hang;
        rd(`PMF_OFS_CTRL, `PMF_CTRL_RESET, `PMF_RESP_OKAY);
        rd(32'h0000_0040, 32'h0, `PMF_RESP_SLVERR);
        wr(32'h0000_0040, 32'h1, `PMF_RESP_SLVERR);
        wr(`PMF_OFS_PT, 32'h20, `PMF_RESP_OKAY);
        wr(32'h0000_107c, 32'h10, `PMF_RESP_OKAY);
        wr(32'h0000_1258, 32'h20, `PMF_RESP_OKAY);
        wr(32'h0000_12d8, 32'h200, `PMF_RESP_OKAY);
        wr(`PMF_OFS_CELL + 32'h4, 32'h0010_0001, `PMF_RESP_OKAY);
        wr(`PMF_OFS_CELL + 32'h8, 32'h0011_0061, `PMF_RESP_OKAY);
        wr(`PMF_OFS_CELL + 32'hc, 32'h0000_0001, `PMF_RESP_OKAY);
        wr(`PMF_OFS_CELL + 32'h10, 32'h0011_0400, `PMF_RESP_OKAY);
        wr(`PMF_OFS_CELL + 32'h18, 32'h0011_0001, `PMF_RESP_OKAY);
        for (i = 0; i < 9; i++) begin
            wr(`PMF_OFS_CELL, rows[i][39:8], `PMF_RESP_OKAY);
            want_ded <= rows[i][7:4];
            want_io[1] <= rows[i][3];
            // fold and feedback each add a registered stage, so allow slack
            tick(8);
            chk(32'(rows[i][2]), 32'(io_out[0]));
            chk(32'(rows[i][1]), 32'(io_oe[0]));
            chk(32'(rows[i][2]), 32'(io_out[1]));
            chk(32'(!rows[i][3]), 32'(io_out[6]));
        end
        snap = io_out;
        tick(1);
        chk(32'(!snap[2]), 32'(io_out[2]));
        chk(32'h1, 32'(io_out[4]));
        chk(32'h1, 32'(io_out[3]));
        wr(`PMF_OFS_CELL, 32'h0011_0001, `PMF_RESP_OKAY);
        tick(8);
        want_io_fl[1] <= 1'b1;
        tick(8);
        chk(32'h1, 32'(io_out[0]));
        wr(`PMF_OFS_CTRL, 32'h0, `PMF_RESP_OKAY);
        tick(8);
        chk(32'h0, 32'(io_out[0]));
        want_io_fl[1] <= 1'b0;
        wr(`PMF_OFS_CTRL, 32'h3, `PMF_RESP_OKAY);
        want_io[31] <= 1'b1;
        tick(8);
        rd(`PMF_OFS_STATUS, 32'h1, `PMF_RESP_OKAY);
        chk(32'h0, 32'(io_oe[31]));
        snap = io_out;
        want_io[1] <= 1'b0;
        tick(8);
        chk(snap, io_out);
        want_io[31] <= 1'b0;
        tick(8);
        chk(32'h0, 32'(io_out[0]));
        rd(`PMF_OFS_STATUS, 32'h0, `PMF_RESP_OKAY);
        resetn <= 1'b0;
        tick(2);
        chk(32'h0, io_out);
        chk(32'h0, io_oe);
        resetn <= 1'b1;
        for (i = 0; i < 100 && s_axi_awready !== 1'b1; i++) tick(1);
        if (i == 100) hang;
        rd(`PMF_OFS_CTRL, `PMF_CTRL_RESET, `PMF_RESP_OKAY);
        print_verdict;
    end
endmodule
